// ---- rtl/pwr_off_pkg.sv ----
package pwr_off_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_REGS = 7;
  localparam int ORDER_W  = 3;
  localparam int DATA_W   = 32;
  localparam int ADDR_W   = 8;

  // ****************************************************************
  // Register indices (word addresses on the bus)
  // ****************************************************************
  // Regulator slots: 0 buck one, 1 buck two, 2 buck three, 3 linear one,
  // 4 linear two, 5 linear three, 6 memory reference.
  localparam logic [ADDR_W-1:0] BUCK_ONE_OFF_ORDER_IDX         = 8'h60;
  localparam logic [ADDR_W-1:0] BUCK_TWO_OFF_ORDER_IDX         = 8'h61;
  localparam logic [ADDR_W-1:0] LINEAR_REG_ONE_OFF_ORDER_IDX   = 8'h62;
  localparam logic [ADDR_W-1:0] LINEAR_REG_TWO_OFF_ORDER_IDX   = 8'h63;
  localparam logic [ADDR_W-1:0] LINEAR_REG_THREE_OFF_ORDER_IDX = 8'h64;
  localparam logic [ADDR_W-1:0] BUCK_THREE_OFF_ORDER_IDX       = 8'h65;
  localparam logic [ADDR_W-1:0] MEM_REFERENCE_OFF_ORDER_IDX    = 8'h66;
  localparam logic [ADDR_W-1:0] OFF_STATUS_IDX                 = 8'h70;

  localparam logic [ADDR_W-1:0] ORDER_IDX [NUM_REGS] = '{
    BUCK_ONE_OFF_ORDER_IDX, BUCK_TWO_OFF_ORDER_IDX, BUCK_THREE_OFF_ORDER_IDX,
    LINEAR_REG_ONE_OFF_ORDER_IDX, LINEAR_REG_TWO_OFF_ORDER_IDX,
    LINEAR_REG_THREE_OFF_ORDER_IDX, MEM_REFERENCE_OFF_ORDER_IDX};

  // ****************************************************************
  // Fields
  // ****************************************************************
  localparam int ORDER_LSB       = 0;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_DONE_BIT   = 1;
  localparam int STAT_ENABLE_LSB = 8;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_FREQ_MHZ = 40;
  localparam int STEP_TIME_NS = 1000;
  localparam int STEP_CYCLES  = (STEP_TIME_NS * CLK_FREQ_MHZ) / 1000;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RUN  = 2'b01,
    SEQ_DONE = 2'b10
  } seq_state_t;

endpackage

// ---- rtl/regulator_power_down_order.sv ----
`timescale 1ns/1ps

module regulator_power_down_order #(
  parameter int STEP_CYCLES = pwr_off_pkg::STEP_CYCLES
) (
  input  wire logic                                             clk,
  input  wire logic                                             rstn,
  input  wire logic [pwr_off_pkg::ADDR_W-1:0]                   address,
  input  wire logic                                             read,
  input  wire logic                                             write,
  input  wire logic [pwr_off_pkg::DATA_W-1:0]                   writedata,
  output logic      [pwr_off_pkg::DATA_W-1:0]                   readdata,
  output logic                                                  waitrequest,
  input  wire logic [pwr_off_pkg::NUM_REGS*pwr_off_pkg::ORDER_W-1:0] fusedOrder,
  input  wire logic                                             systemOn,
  input  wire logic                                             shutdownReq,
  output logic      [pwr_off_pkg::NUM_REGS-1:0]                 regEnable,
  output logic                                                  shutdownBusy,
  output logic                                                  shutdownDone
);

  localparam int N  = pwr_off_pkg::NUM_REGS;
  localparam int OW = pwr_off_pkg::ORDER_W;
  localparam int CW = $clog2(STEP_CYCLES + 1);
  localparam logic [CW-1:0] STEP_LAST = CW'(STEP_CYCLES - 1);

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [OW-1:0]                  orderQ [N];
  logic [OW-1:0]                  orderD [N];
  logic                           waitQ, waitD;
  logic [pwr_off_pkg::DATA_W-1:0] rdataQ, rdataD;
  logic                           writeTaken;
  logic [N-1:0]                   enQ, enD, hitMask;
  pwr_off_pkg::seq_state_t        stateQ, stateD;
  logic [CW-1:0]                  cntQ, cntD;
  logic                           busyD, doneD;
  logic                           stepFire;
  logic [OW-1:0]                  maxOrder;
  logic                           allZero;

  // Every request gets exactly one wait state; the write lands and the
  // read data is sampled at the edge where waitrequest is seen low.
  assign writeTaken = write && !waitQ;

  always_comb begin
    waitD  = 1'b1;
    rdataD = rdataQ;
    if ((read || write) && waitQ) begin
      waitD  = 1'b0;
      rdataD = pwr_off_pkg::READ_ZERO;
      for (int i = 0; i < N; i++) begin
        if (address == pwr_off_pkg::ORDER_IDX[i]) begin
          rdataD[pwr_off_pkg::ORDER_LSB +: OW] = orderQ[i];
        end
      end
      if (address == pwr_off_pkg::OFF_STATUS_IDX) begin
        rdataD[pwr_off_pkg::STAT_BUSY_BIT]         = shutdownBusy;
        rdataD[pwr_off_pkg::STAT_DONE_BIT]         = shutdownDone;
        rdataD[pwr_off_pkg::STAT_ENABLE_LSB +: N]  = enQ;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      waitQ  <= 1'b1;
      rdataQ <= pwr_off_pkg::READ_ZERO;
    end else begin
      waitQ  <= waitD;
      rdataQ <= rdataD;
    end
  end

  assign waitrequest = waitQ;
  assign readdata    = rdataQ;

  // ****************************************************************
  // Order fields and per-regulator step decisions
  // ****************************************************************
  generate
    for (genvar g = 0; g < N; g++) begin : gen_reg
      always_comb begin
        orderD[g] = orderQ[g];
        if (writeTaken && systemOn && address == pwr_off_pkg::ORDER_IDX[g]) begin
          orderD[g] = writedata[pwr_off_pkg::ORDER_LSB +: OW];
        end
      end

      always_ff @(posedge clk) begin
        if (!rstn) begin
          orderQ[g] <= fusedOrder[g*OW +: OW];
        end else begin
          orderQ[g] <= orderD[g];
        end
      end

      assign hitMask[g] = enQ[g] && (orderQ[g] == maxOrder);
    end
  endgenerate

  always_comb begin
    maxOrder = '0;
    allZero  = 1'b1;
    for (int i = 0; i < N; i++) begin
      if (enQ[i] && orderQ[i] > maxOrder) begin
        maxOrder = orderQ[i];
      end
      if (orderQ[i] != '0) begin
        allZero = 1'b0;
      end
    end
  end

  // ****************************************************************
  // Shutdown sequencer
  // ****************************************************************
  // The step divider only runs while sequencing, so the first step comes
  // one full step time after the request and the rest follow evenly.
  assign stepFire = (stateQ == pwr_off_pkg::SEQ_RUN) && (cntQ == STEP_LAST);

  always_comb begin
    stateD = stateQ;
    enD    = enQ;
    cntD   = cntQ;
    unique case (stateQ)
      pwr_off_pkg::SEQ_IDLE: begin
        if (shutdownReq) begin
          if (allZero) begin
            enD    = '0;
            stateD = pwr_off_pkg::SEQ_DONE;
          end else begin
            cntD   = '0;
            stateD = pwr_off_pkg::SEQ_RUN;
          end
        end
      end
      pwr_off_pkg::SEQ_RUN: begin
        cntD = (cntQ == STEP_LAST) ? '0 : cntQ + CW'(1);
        if (stepFire) begin
          enD = enQ & ~hitMask;
          if ((enQ & ~hitMask) == '0) begin
            stateD = pwr_off_pkg::SEQ_DONE;
          end
        end
      end
      pwr_off_pkg::SEQ_DONE: begin
        stateD = pwr_off_pkg::SEQ_DONE;
      end
      default: begin
        stateD = pwr_off_pkg::SEQ_IDLE;
      end
    endcase
    busyD = (stateD == pwr_off_pkg::SEQ_RUN);
    doneD = (stateD == pwr_off_pkg::SEQ_DONE);
  end

  // Regulators stay off once the sequence finishes; only reset restores them.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stateQ       <= pwr_off_pkg::SEQ_IDLE;
      enQ          <= '1;
      cntQ         <= '0;
      shutdownBusy <= 1'b0;
      shutdownDone <= 1'b0;
    end else begin
      stateQ       <= stateD;
      enQ          <= enD;
      cntQ         <= cntD;
      shutdownBusy <= busyD;
      shutdownDone <= doneD;
    end
  end

  assign regEnable = enQ;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic [N*OW-1:0] orderFlat;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      orderFlat[i*OW +: OW] = orderQ[i];
    end
  end

  sequence s_write_on_buck_one;
    write && !waitQ && systemOn && address == pwr_off_pkg::BUCK_ONE_OFF_ORDER_IDX;
  endsequence

  sequence s_order_read;
    (read && waitQ && address == pwr_off_pkg::LINEAR_REG_ONE_OFF_ORDER_IDX) ##1 !waitQ;
  endsequence

  property p_high_bits_zero;
    s_order_read |-> rdataQ[pwr_off_pkg::DATA_W-1:OW] == '0 && rdataQ[OW-1:0] == orderQ[3];
  endproperty
  a_high_bits_zero: assert property (p_high_bits_zero)
    else $error("order readback has nonzero upper bits or wrong field");

  property p_reset_mirror;
    $rose(rstn) |-> orderFlat == $past(fusedOrder);
  endproperty
  a_reset_mirror: assert property (p_reset_mirror)
    else $error("off-order fields do not mirror fused order after reset");

  property p_descending;
    stepFire && (enQ & ~hitMask) != '0 |=> maxOrder < $past(maxOrder) && enQ != $past(enQ);
  endproperty
  a_descending: assert property (p_descending)
    else $error("step did not remove the highest remaining order");

  property p_all_zero_bypass;
    stateQ == pwr_off_pkg::SEQ_IDLE && shutdownReq && allZero |=> enQ == '0 ##1 shutdownDone;
  endproperty
  a_all_zero_bypass: assert property (p_all_zero_bypass)
    else $error("all-zero orders did not switch everything off at once");

  property p_write_applied;
    s_write_on_buck_one |=> orderQ[0] == $past(writedata[OW-1:0]);
  endproperty
  a_write_applied: assert property (p_write_applied)
    else $error("write while on was not applied");

  property p_no_write_when_off;
    !(write && systemOn) |=> $stable(orderFlat);
  endproperty
  a_no_write_when_off: assert property (p_no_write_when_off)
    else $error("order fields changed without a permitted write");

  property p_zero_last;
    stepFire && maxOrder == '0 |=> enQ == '0 ##1 shutdownDone && !shutdownBusy;
  endproperty
  a_zero_last: assert property (p_zero_last)
    else $error("zero-valued regulators not all switched off in final step");

endmodule

// ---- tb/host_model.sv ----
`timescale 1ns/1ps

// ****************************************************************
// Host side of the register bus
// ****************************************************************
module host_model (
  input  wire logic       clk,
  input  wire logic       systemOn,
  input  wire logic       waitrequest,
  output logic      [7:0]  address,
  output logic            read,
  output logic            write,
  output logic      [31:0] writedata
);
  initial begin
    address   = 8'h00;
    read      = 1'b0;
    write     = 1'b0;
    writedata = 32'h0000_0000;
  end

  task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic isWr);
    @(posedge clk);
    address   <= a;
    writedata <= d;
    write     <= isWr;
    read      <= !isWr;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    // Released lines show garbage so a stale value is never mistaken for live data.
    write     <= 1'b0;
    read      <= 1'b0;
    address   <= ~a;
    writedata <= ~d;
  endtask

  // host writes only in system-on states, unless a test asks otherwise.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic anyState);
    if (!anyState) wait (systemOn === 1'b1);
    xfer(a, d, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(a, 32'h0000_0000, 1'b0);
  endtask
endmodule

// ---- tb/regulator_power_down_order_tb.sv ----
`timescale 1ns/1ps

module regulator_power_down_order_tb;
  localparam int STEP = 3;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [20:0] fusedOrder = 21'h000000;
  logic        systemOn = 1'b1;
  logic        shutdownReq = 1'b0;
  logic [6:0]  regEnable;
  logic        shutdownBusy;
  logic        shutdownDone;
  int          mismatches = 0;
  int          checksDone = 0;
  int          seed = 22;
  logic [31:0] expQ [$];
  logic [2:0]  field [7];

  always #12.5 clk = ~clk;

  regulator_power_down_order #(.STEP_CYCLES(STEP)) regulator_power_down_order_i (
    .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .fusedOrder(fusedOrder), .systemOn(systemOn), .shutdownReq(shutdownReq),
    .regEnable(regEnable), .shutdownBusy(shutdownBusy), .shutdownDone(shutdownDone));

  host_model host_model_i (
    .clk(clk), .systemOn(systemOn), .waitrequest(waitrequest), .address(address),
    .read(read), .write(write), .writedata(writedata));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Read answers are matched against the oldest expectation
  // ****************************************************************
  always @(posedge clk) begin
    if (read === 1'b1 && waitrequest === 1'b0)
      check("readdata", readdata, expQ.size() > 0 ? expQ.pop_front() : 'x);
  end

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    host_model_i.rd(a);
  endtask

  task automatic doReset(input logic [20:0] f);
    rstn        <= 1'b0;
    fusedOrder  <= f;
    systemOn    <= 1'b1;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) field[i] = f[3*i+:3];
  endtask

  task automatic readAll;
    for (int i = 0; i < 7; i++) rd(pwr_off_pkg::ORDER_IDX[i], {29'h0, field[i]});
  endtask

  task automatic setFields(input logic [20:0] p);
    for (int i = 0; i < 7; i++) begin
      host_model_i.wr(pwr_off_pkg::ORDER_IDX[i], {$random(seed)} << 3 | p[3*i+:3], 1'b0);
      field[i] = p[3*i+:3];
    end
  endtask

  // Steps are derived from the field values: highest first, zeros last, all at once if all zero.
  task automatic runOff;
    logic [6:0] en;
    logic [6:0] nxt;
    logic       allZero;
    logic       first;
    int         guard;
    en      = 7'h7f;
    first   = 1'b1;
    allZero = 1'b1;
    for (int s = 0; s < 7; s++) if (field[s] != 3'h0) allZero = 1'b0;
    @(posedge clk);
    shutdownReq <= 1'b1;
    @(posedge clk);
    shutdownReq <= 1'b0;
    for (int v = 7; v >= 0; v--) begin
      nxt = en;
      for (int s = 0; s < 7; s++) if (field[s] == v[2:0]) nxt[s] = 1'b0;
      if (nxt != en) begin
        guard = 0;
        while (regEnable === en && guard < 4 * STEP) begin
          @(posedge clk);
          guard++;
        end
        check("regEnable", {25'h0, regEnable}, {25'h0, nxt});
        check("stepGap", guard, allZero ? 1 : (first ? STEP + 1 : STEP));
        check("busyStep", {31'h0, shutdownBusy}, {31'h0, nxt != 7'h00});
        en    = nxt;
        first = 1'b0;
      end
    end
    check("doneBusy", {30'h0, shutdownDone, shutdownBusy}, 32'h0000_0002);
    rd(pwr_off_pkg::OFF_STATUS_IDX, 32'h0000_0002);
  endtask

  initial begin
    doReset(21'($random(seed)));
    readAll;
    rd(8'h10, 32'h0000_0000);
    rd(pwr_off_pkg::OFF_STATUS_IDX, 32'h0000_7f00);
    setFields(21'($random(seed)));
    readAll;
    systemOn <= 1'b0;
    host_model_i.wr(pwr_off_pkg::ORDER_IDX[0], {29'h0, ~field[0]}, 1'b1);
    readAll;
    systemOn <= 1'b1;
    host_model_i.wr(pwr_off_pkg::OFF_STATUS_IDX, 32'hffff_ffff, 1'b0);
    rd(pwr_off_pkg::OFF_STATUS_IDX, 32'h0000_7f00);
    setFields(21'h000243);
    runOff;
    doReset(21'h000000);
    readAll;
    runOff;
    doReset(21'($random(seed)));
    readAll;
    runOff;
    conclude;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude;
  end
endmodule
